/* src/xlc_pkg.sv */
// Package with the register map, field positions and reset values of the lane control bank
// Behaviour
// - All-lane sync bit 11 reads one only while every lane stays synced.
// - Control bit 3 reverses bits of each lane word leaving receive path.
// - Control bit 2 reverses bits of each lane word from receive macros.
// - Control bit 1 reverses bits of each lane word from XGMII transmit.
// - Control bit 0 reverses bits of each lane word sent to serializer.
// - Loopback bit 1 routes receive data and control into transmit path.
// - Loopback bit 0 routes the 40-bit transmit word into receive path.
// - Both loopbacks are inert while the standard loopback bit is set.
// - Bypass bit 15 stops idle code-group substitution on transmit.
// - Bypass bit 11 disables transmit clock tolerance compensation.
// - Bypass bits 7 to 4 disable encoding on lanes 3 to 0.
// - Per-lane rate compensation overflow latched in bits 9 to 6.
// - Per-lane rate compensation underflow latched in bits 5 to 2.
// - Summary bit 1 for any overflow, bit 0 for any underflow.
// - Idle insert count is 16 bits, resets to fffd, clears on read.
// - Idle delete count is 16 bits, resets to fffd, clears on read.
// - Lane data-down flag sets after 4095 cycles without toggle, clears on read.
package xlc_pkg;
    // Register addresses
    localparam logic [15:0] ADDR_SYNC = 16'h8016;
    localparam logic [15:0] ADDR_BITREV = 16'h8017;
    localparam logic [15:0] ADDR_LOOP = 16'h8018;
    localparam logic [15:0] ADDR_TXBYP = 16'h8019;
    localparam logic [15:0] ADDR_RATE = 16'h801a;
    localparam logic [15:0] ADDR_INS = 16'h801b;
    localparam logic [15:0] ADDR_DEL = 16'h801c;
    localparam logic [15:0] ADDR_DOWN = 16'h801d;
    // Field positions
    localparam int SYNC_BIT = 11;
    localparam int REV_XGMII_RX = 3;
    localparam int REV_XAUI_RX = 2;
    localparam int REV_XGMII_TX = 1;
    localparam int REV_XAUI_TX = 0;
    localparam int LOOP_XAUI = 1;
    localparam int LOOP_XGMII = 0;
    localparam int BYP_IDLE = 15;
    localparam int BYP_RATE = 11;
    localparam int BYP_ENC_LO = 4;
    localparam int OVF_LO = 6;
    localparam int UDF_LO = 2;
    localparam int OVF_ANY = 1;
    localparam int UDF_ANY = 0;
    // Reset values and writable masks
    localparam logic [15:0] BITREV_RST = 16'h0005;
    localparam logic [15:0] BITREV_MASK = 16'h000f;
    localparam logic [15:0] LOOP_MASK = 16'h0003;
    localparam logic [15:0] TXBYP_MASK = 16'h88f0;
    localparam logic [15:0] TALLY_RST = 16'hfffd;
    localparam logic [15:0] TALLY_MAX = 16'hffff;
    // Inactivity limit in cycles of the lane clock
    localparam int IDLE_LIMIT = 4095;
    localparam int IDLE_CNT_W = 12;
endpackage

/* src/xlc_lane_ctrl_status_regs.sv */
// Lane control and status register bank behind the management register port
`timescale 1ns/1ps
`default_nettype none
module xlc_lane_ctrl_status_regs #(
    parameter int LANES = 4,
    parameter int IDLE_LIMIT = xlc_pkg::IDLE_LIMIT
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [15:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [15:0] regWrData,
    output logic [15:0] regRdData,
    output logic regRdValid,
    input wire logic [LANES-1:0] laneSync,
    input wire logic [LANES-1:0] rateOverflow,
    input wire logic [LANES-1:0] rateUnderflow,
    input wire logic idleInsert,
    input wire logic idleDelete,
    input wire logic [LANES-1:0] laneToggle,
    input wire logic stdLoopback,
    output logic revXgmiiRx,
    output logic revXauiRx,
    output logic revXgmiiTx,
    output logic revXauiTx,
    output logic xauiLoopbackEn,
    output logic xgmiiLoopbackEn,
    output logic idleMgmtBypass,
    output logic txRateCompBypass,
    output logic [LANES-1:0] encoderBypass
);
    localparam logic [xlc_pkg::IDLE_CNT_W-1:0] LIMIT_M1 =
        xlc_pkg::IDLE_CNT_W'(IDLE_LIMIT - 1);

    logic [15:0] bitRevCtrl;
    logic [15:0] loopCtrl;
    logic [15:0] txBypCtrl;
    logic syncFlag;
    logic [15:0] rateFlags;
    logic [15:0] insertTally;
    logic [15:0] deleteTally;
    logic [LANES-1:0] downFlags;
    logic [xlc_pkg::IDLE_CNT_W-1:0] idleCnt [LANES];
    logic loopXauiQ;
    logic loopXgmiiQ;

    // Address decode
    wire selSync = (regAddr == xlc_pkg::ADDR_SYNC);
    wire selRev = (regAddr == xlc_pkg::ADDR_BITREV);
    wire selLoop = (regAddr == xlc_pkg::ADDR_LOOP);
    wire selByp = (regAddr == xlc_pkg::ADDR_TXBYP);
    wire selRate = (regAddr == xlc_pkg::ADDR_RATE);
    wire selIns = (regAddr == xlc_pkg::ADDR_INS);
    wire selDel = (regAddr == xlc_pkg::ADDR_DEL);
    wire selDown = (regAddr == xlc_pkg::ADDR_DOWN);
    wire rdSync = regRdEn && selSync;
    wire rdRate = regRdEn && selRate;
    wire rdIns = regRdEn && selIns;
    wire rdDel = regRdEn && selDel;
    wire rdDown = regRdEn && selDown;

    // Status next values; a read reloads with the present condition
    wire allSync = &laneSync;
    wire next_syncFlag = rdSync ? allSync : (syncFlag & allSync);
    wire [15:0] rateEvents = {6'h00, rateOverflow, rateUnderflow, |rateOverflow,
        |rateUnderflow};
    wire [15:0] next_rateFlags = (rdRate ? 16'h0000 : rateFlags) | rateEvents;
    wire [15:0] insBase = rdIns ? 16'h0000 : insertTally;
    wire [15:0] delBase = rdDel ? 16'h0000 : deleteTally;
    wire [15:0] next_insertTally = (idleInsert && insBase != xlc_pkg::TALLY_MAX) ?
        insBase + 16'h0001 : insBase;
    wire [15:0] next_deleteTally = (idleDelete && delBase != xlc_pkg::TALLY_MAX) ?
        delBase + 16'h0001 : delBase;

    // Per-lane inactivity detection
    logic [LANES-1:0] downHit;
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : gLane
            assign downHit[g] = !laneToggle[g] && (idleCnt[g] == LIMIT_M1);
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    idleCnt[g] <= '0;
                end else if (laneToggle[g]) begin
                    idleCnt[g] <= '0;
                end else if (idleCnt[g] != LIMIT_M1 + 1'b1) begin
                    idleCnt[g] <= idleCnt[g] + 1'b1;
                end
            end

            // Counter restart, stop point and flag set per lane
            a_cnt_restart: assert property (@(posedge clk) disable iff (!rstn)
                laneToggle[g] |=> idleCnt[g] == '0)
                else $error("inactivity counter not restarted by toggle");
            a_cnt_bound: assert property (@(posedge clk) disable iff (!rstn)
                idleCnt[g] <= LIMIT_M1 + 1'b1)
                else $error("inactivity counter ran past its stop");
            a_down_lane: assert property (@(posedge clk) disable iff (!rstn)
                downHit[g] |=> downFlags[g])
                else $error("data down flag missed its lane hit");
        end
    endgenerate
    wire [LANES-1:0] next_downFlags = (rdDown ? '0 : downFlags) | downHit;

    // Read data mux; unmapped addresses read zero
    wire [15:0] rdMux =
        selSync ? (16'h0000 | (16'(syncFlag) << xlc_pkg::SYNC_BIT)) :
        selRev ? bitRevCtrl :
        selLoop ? loopCtrl :
        selByp ? txBypCtrl :
        selRate ? rateFlags :
        selIns ? insertTally :
        selDel ? deleteTally :
        selDown ? 16'(downFlags) : 16'h0000;

    // Control registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            bitRevCtrl <= xlc_pkg::BITREV_RST;
            loopCtrl <= 16'h0000;
            txBypCtrl <= 16'h0000;
        end else if (regWrEn) begin
            if (selRev) bitRevCtrl <= regWrData & xlc_pkg::BITREV_MASK;
            if (selLoop) loopCtrl <= regWrData & xlc_pkg::LOOP_MASK;
            if (selByp) txBypCtrl <= regWrData & xlc_pkg::TXBYP_MASK;
        end
    end

    // Status registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            syncFlag <= 1'b0;
            rateFlags <= 16'h0000;
            insertTally <= xlc_pkg::TALLY_RST;
            deleteTally <= xlc_pkg::TALLY_RST;
            downFlags <= '0;
        end else begin
            syncFlag <= next_syncFlag;
            rateFlags <= next_rateFlags;
            insertTally <= next_insertTally;
            deleteTally <= next_deleteTally;
            downFlags <= next_downFlags;
        end
    end

    // Read answer one cycle after the request
    always_ff @(posedge clk) begin
        if (!rstn) begin
            regRdData <= 16'h0000;
            regRdValid <= 1'b0;
        end else begin
            regRdData <= regRdEn ? rdMux : 16'h0000;
            regRdValid <= regRdEn;
        end
    end

    // Loopback selects gated by the standard loopback bit
    always_ff @(posedge clk) begin
        if (!rstn) begin
            loopXauiQ <= 1'b0;
            loopXgmiiQ <= 1'b0;
        end else begin
            loopXauiQ <= loopCtrl[xlc_pkg::LOOP_XAUI] && !stdLoopback;
            loopXgmiiQ <= loopCtrl[xlc_pkg::LOOP_XGMII] && !stdLoopback;
        end
    end

    // Datapath steering from the control flops; loopback enables from the gated select flops
    assign revXgmiiRx = bitRevCtrl[xlc_pkg::REV_XGMII_RX];
    assign revXauiRx = bitRevCtrl[xlc_pkg::REV_XAUI_RX];
    assign revXgmiiTx = bitRevCtrl[xlc_pkg::REV_XGMII_TX];
    assign revXauiTx = bitRevCtrl[xlc_pkg::REV_XAUI_TX];
    assign xauiLoopbackEn = loopXauiQ;
    assign xgmiiLoopbackEn = loopXgmiiQ;
    assign idleMgmtBypass = txBypCtrl[xlc_pkg::BYP_IDLE];
    assign txRateCompBypass = txBypCtrl[xlc_pkg::BYP_RATE];
    assign encoderBypass = txBypCtrl[xlc_pkg::BYP_ENC_LO +: LANES];

    // Checks
    a_sync_low_hold: assert property (@(posedge clk) disable iff (!rstn)
        !(&laneSync) |=> !syncFlag ##1 (!syncFlag || $past(rdSync)))
        else $error("sync flag did not stay low after loss");

    a_bitrev_write: assert property (@(posedge clk) disable iff (!rstn)
        (regWrEn && selRev) |=> ({revXgmiiRx, revXauiRx, revXgmiiTx, revXauiTx}
        == $past(regWrData[3:0])))
        else $error("bit order outputs do not follow write");

    a_xaui_loop: assert property (@(posedge clk) disable iff (!rstn)
        (loopCtrl[1] && !stdLoopback) |=> xauiLoopbackEn)
        else $error("receive to transmit loopback not enabled");

    a_xgmii_loop: assert property (@(posedge clk) disable iff (!rstn)
        (loopCtrl[0] && !stdLoopback) |=> xgmiiLoopbackEn)
        else $error("transmit to receive loopback not enabled");

    a_loop_gate: assert property (@(posedge clk) disable iff (!rstn)
        stdLoopback |=> !xauiLoopbackEn && !xgmiiLoopbackEn)
        else $error("loopback active under standard loopback");

    a_txbyp_write: assert property (@(posedge clk) disable iff (!rstn)
        (regWrEn && selByp) |=> idleMgmtBypass == $past(regWrData[15]) &&
        txRateCompBypass == $past(regWrData[11]) &&
        encoderBypass == $past(regWrData[7:4]))
        else $error("transmit bypass outputs do not follow write");

    a_ovf_latch: assert property (@(posedge clk) disable iff (!rstn)
        |rateOverflow |=> rateFlags[1] && rateFlags[9:6] == ($past(rateFlags[9:6]) &
        {4{!$past(rdRate)}} | $past(rateOverflow)))
        else $error("overflow not latched");

    a_udf_latch: assert property (@(posedge clk) disable iff (!rstn)
        |rateUnderflow |=> rateFlags[0] && (rateFlags[5:2] & $past(rateUnderflow))
        == $past(rateUnderflow))
        else $error("underflow not latched");

    a_ins_clear: assert property (@(posedge clk) disable iff (!rstn)
        (rdIns && !idleInsert) |=> insertTally == 16'h0000)
        else $error("insert tally not cleared by read");

    a_del_clear: assert property (@(posedge clk) disable iff (!rstn)
        (rdDel && idleDelete) |=> deleteTally == 16'h0001)
        else $error("delete tally read and event mishandled");

    a_down_set: assert property (@(posedge clk) disable iff (!rstn)
        $rose(downFlags[0]) |-> $past(idleCnt[0]) == LIMIT_M1 && !$past(laneToggle[0]))
        else $error("data down flag set at wrong count");

    a_rate_reload: assert property (@(posedge clk) disable iff (!rstn)
        (rdRate && !(|rateOverflow) && !(|rateUnderflow)) |=> rateFlags == 16'h0000)
        else $error("rate flags not reloaded by read");

    a_tally_sat: assert property (@(posedge clk) disable iff (!rstn)
        (insertTally == 16'hffff && !rdIns) |=> insertTally == 16'hffff)
        else $error("insert tally wrapped");

    a_read_answer: assert property (@(posedge clk) disable iff (!rstn)
        (regRdEn && !selSync && !selRev && !selLoop && !selByp && !selRate && !selIns
        && !selDel && !selDown) |=> regRdValid && regRdData == 16'h0000)
        else $error("unmapped read not answered with zero");

    // Read port timing and data; sync flag reload and hold
    a_rd_valid: assert property (@(posedge clk) disable iff (!rstn)
        regRdEn |=> regRdValid)
        else $error("read not answered one cycle later");

    a_rd_quiet: assert property (@(posedge clk) disable iff (!rstn)
        !regRdEn |=> !regRdValid && regRdData == 16'h0000)
        else $error("read port not quiet without a request");

    a_sync_data: assert property (@(posedge clk) disable iff (!rstn)
        rdSync |=> regRdData == (16'($past(syncFlag)) << xlc_pkg::SYNC_BIT))
        else $error("sync read data wrong");

    a_sync_reload: assert property (@(posedge clk) disable iff (!rstn)
        rdSync |=> syncFlag == $past(&laneSync))
        else $error("sync flag not reloaded by read");

    a_sync_keep: assert property (@(posedge clk) disable iff (!rstn)
        (!rdSync && !syncFlag) |=> !syncFlag)
        else $error("sync flag rose without a read");

    // Control register checks
    a_rev_read: assert property (@(posedge clk) disable iff (!rstn)
        (regRdEn && selRev) |=> regRdData == {12'h000, $past(revXgmiiRx), $past(revXauiRx),
        $past(revXgmiiTx), $past(revXauiTx)})
        else $error("bit order read disagrees with outputs");

    a_rev_hold: assert property (@(posedge clk) disable iff (!rstn)
        !(regWrEn && selRev) |=> $stable(bitRevCtrl))
        else $error("bit order register changed without a write");

    a_loop_hold: assert property (@(posedge clk) disable iff (!rstn)
        !(regWrEn && selLoop) |=> $stable(loopCtrl))
        else $error("loopback register changed without a write");

    a_byp_hold: assert property (@(posedge clk) disable iff (!rstn)
        !(regWrEn && selByp) |=> $stable(txBypCtrl))
        else $error("bypass register changed without a write");

    a_xaui_off: assert property (@(posedge clk) disable iff (!rstn)
        !loopCtrl[xlc_pkg::LOOP_XAUI] |=> !xauiLoopbackEn)
        else $error("receive to transmit loopback on while deselected");

    a_xgmii_off: assert property (@(posedge clk) disable iff (!rstn)
        !loopCtrl[xlc_pkg::LOOP_XGMII] |=> !xgmiiLoopbackEn)
        else $error("transmit to receive loopback on while deselected");

    a_loop_write: assert property (@(posedge clk) disable iff (!rstn)
        (regWrEn && selLoop) ##1 !stdLoopback |=> xauiLoopbackEn == $past(regWrData[1], 2)
        && xgmiiLoopbackEn == $past(regWrData[0], 2))
        else $error("loopback enables do not follow write");

    // Rate flag checks
    a_ovf_any: assert property (@(posedge clk) disable iff (!rstn)
        rateFlags[xlc_pkg::OVF_ANY] == |rateFlags[9:6])
        else $error("overflow summary disagrees with lane flags");

    a_udf_any: assert property (@(posedge clk) disable iff (!rstn)
        rateFlags[xlc_pkg::UDF_ANY] == |rateFlags[5:2])
        else $error("underflow summary disagrees with lane flags");

    a_ovf_sticky: assert property (@(posedge clk) disable iff (!rstn)
        !rdRate |=> (rateFlags[9:6] & $past(rateFlags[9:6])) == $past(rateFlags[9:6]))
        else $error("overflow flag dropped without a read");

    a_udf_sticky: assert property (@(posedge clk) disable iff (!rstn)
        !rdRate |=> (rateFlags[5:2] & $past(rateFlags[5:2])) == $past(rateFlags[5:2]))
        else $error("underflow flag dropped without a read");

    // Tally checks
    a_ins_step: assert property (@(posedge clk) disable iff (!rstn)
        (!rdIns && idleInsert && insertTally != 16'hffff) |=>
        insertTally == $past(insertTally) + 16'h0001)
        else $error("insert tally did not step");

    a_ins_still: assert property (@(posedge clk) disable iff (!rstn)
        (!rdIns && !idleInsert) |=> $stable(insertTally))
        else $error("insert tally moved without an event");

    a_ins_read_event: assert property (@(posedge clk) disable iff (!rstn)
        (rdIns && idleInsert) |=> insertTally == 16'h0001)
        else $error("insert tally read and event mishandled");

    a_del_step: assert property (@(posedge clk) disable iff (!rstn)
        (!rdDel && idleDelete && deleteTally != 16'hffff) |=>
        deleteTally == $past(deleteTally) + 16'h0001)
        else $error("delete tally did not step");

    a_del_still: assert property (@(posedge clk) disable iff (!rstn)
        (!rdDel && !idleDelete) |=> $stable(deleteTally))
        else $error("delete tally moved without an event");

    a_del_read_quiet: assert property (@(posedge clk) disable iff (!rstn)
        (rdDel && !idleDelete) |=> deleteTally == 16'h0000)
        else $error("delete tally not cleared by read");

    a_del_sat: assert property (@(posedge clk) disable iff (!rstn)
        (deleteTally == 16'hffff && !rdDel) |=> deleteTally == 16'hffff)
        else $error("delete tally wrapped");

    // Data down checks
    a_down_clear: assert property (@(posedge clk) disable iff (!rstn)
        (rdDown && !(|downHit)) |=> downFlags == '0)
        else $error("data down flags not cleared by read");

    a_down_sticky: assert property (@(posedge clk) disable iff (!rstn)
        !rdDown |=> (downFlags & $past(downFlags)) == $past(downFlags))
        else $error("data down flag dropped without a read");

    a_down_read: assert property (@(posedge clk) disable iff (!rstn)
        rdDown |=> regRdData == 16'($past(downFlags)))
        else $error("data down read data wrong");
endmodule
`default_nettype wire

/* src/xlc_pkg_unused_guard.sv */
// Empty compile unit; all logic lives in the register bank file
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* verif/xlc_mgmt_host.sv */
// Management host model driving the register strobe port
`timescale 1ns/1ps
`default_nettype none
module xlc_mgmt_host (
    input wire logic clk,
    output logic [15:0] regAddr,
    output logic regWrEn,
    output logic regRdEn,
    output logic [15:0] regWrData,
    input wire logic [15:0] regRdData,
    input wire logic regRdValid
);
    // Idle port
    initial begin
        regAddr = 16'h0000;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regWrData = 16'h0000;
    end
    // One write strobe; address and data scrambled once released
    task automatic wr(input logic [15:0] addr, input logic [15:0] data);
        @(negedge clk);
        regAddr = addr;
        regWrData = data;
        regWrEn = 1'b1;
        @(negedge clk);
        regWrEn = 1'b0;
        regAddr = ~addr;
        regWrData = ~data;
    endtask
    // One read strobe; data taken while the valid flag stands
    task automatic rd(input logic [15:0] addr, output logic [15:0] data, output logic ok);
        int i;
        @(negedge clk);
        regAddr = addr;
        regRdEn = 1'b1;
        @(negedge clk);
        regRdEn = 1'b0;
        regAddr = ~addr;
        ok = 1'b0;
        data = 16'h0000;
        for (i = 0; i < 4 && !ok; i++) begin
            if (regRdValid === 1'b1) begin
                ok = 1'b1;
                data = regRdData;
            end else begin
                @(negedge clk);
            end
        end
    endtask
endmodule
`default_nettype wire

/* verif/xlc_lane_ctrl_status_regs_tb.sv */
// Self-checking bench for the lane control and status register bank
`timescale 1ns/1ps
`default_nettype none
module xlc_lane_ctrl_status_regs_tb;
    localparam int LIM = 8;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] regAddr, regWrData, regRdData;
    logic regWrEn, regRdEn, regRdValid;
    logic [3:0] laneSync = 4'h0, rateOverflow = 4'h0, rateUnderflow = 4'h0, laneToggle = 4'hf;
    logic idleInsert = 1'b0, idleDelete = 1'b0, stdLoopback = 1'b1;
    logic revXgmiiRx, revXauiRx, revXgmiiTx, revXauiTx, xauiLoopbackEn, xgmiiLoopbackEn;
    logic idleMgmtBypass, txRateCompBypass;
    logic [3:0] encoderBypass;
    logic [15:0] rstVal [8] = '{16'h0000, 16'h0005, 16'h0000, 16'h0000,
        16'h0000, 16'hfffd, 16'hfffd, 16'h0000};
    int nMismatch = 0;
    int nTests = 0;
    xlc_mgmt_host xlc_mgmt_host_inst (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid));
    xlc_lane_ctrl_status_regs #(.LANES(4), .IDLE_LIMIT(LIM)) xlc_lane_ctrl_status_regs_inst (
        .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
        .laneSync(laneSync), .rateOverflow(rateOverflow), .rateUnderflow(rateUnderflow),
        .idleInsert(idleInsert), .idleDelete(idleDelete), .laneToggle(laneToggle),
        .stdLoopback(stdLoopback), .revXgmiiRx(revXgmiiRx), .revXauiRx(revXauiRx),
        .revXgmiiTx(revXgmiiTx), .revXauiTx(revXauiTx), .xauiLoopbackEn(xauiLoopbackEn),
        .xgmiiLoopbackEn(xgmiiLoopbackEn), .idleMgmtBypass(idleMgmtBypass),
        .txRateCompBypass(txRateCompBypass), .encoderBypass(encoderBypass));
    // Clock, 50 ns period
    always #25 clk = ~clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        nTests++;
        if (seen !== exp) begin
            nMismatch++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic completeRun();
        if (nMismatch == 0 && nTests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Read and compare; an unanswered read ends the run
    task automatic rdChk(input logic [15:0] addr, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        xlc_mgmt_host_inst.rd(addr, d, ok);
        if (ok !== 1'b1) begin
            nMismatch++;
            $display("Error at %0t: read not answered", $time);
            completeRun();
        end else begin
            check(d, exp);
        end
    endtask
    task automatic doReset();
        rstn = 1'b0;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
    endtask
    // Main sequence
    initial begin
        doReset();
        for (int i = 0; i < 8; i++) begin
            rdChk(xlc_pkg::ADDR_SYNC + 16'(i), rstVal[i]);
        end
        check({12'h000, revXgmiiRx, revXauiRx, revXgmiiTx, revXauiTx}, 16'h0005);
        rdChk(xlc_pkg::ADDR_INS, 16'h0000);
        rdChk(16'h8000, 16'h0000);
        xlc_mgmt_host_inst.wr(xlc_pkg::ADDR_BITREV, 16'hfffa);
        rdChk(xlc_pkg::ADDR_BITREV, 16'h000a);
        check({12'h000, revXgmiiRx, revXauiRx, revXgmiiTx, revXauiTx}, 16'h000a);
        xlc_mgmt_host_inst.wr(xlc_pkg::ADDR_TXBYP, 16'hffff);
        rdChk(xlc_pkg::ADDR_TXBYP, 16'h88f0);
        check({10'h000, idleMgmtBypass, txRateCompBypass, encoderBypass}, 16'h003f);
        xlc_mgmt_host_inst.wr(xlc_pkg::ADDR_TXBYP, 16'h0010);
        check({10'h000, idleMgmtBypass, txRateCompBypass, encoderBypass}, 16'h0001);
        // Loopback held off by the standard bit, then released when the bench clears that bit
        xlc_mgmt_host_inst.wr(xlc_pkg::ADDR_LOOP, 16'h0003);
        repeat (2) @(negedge clk);
        check({14'h0000, xauiLoopbackEn, xgmiiLoopbackEn}, 16'h0000);
        stdLoopback = 1'b0;
        repeat (2) @(negedge clk);
        check({14'h0000, xauiLoopbackEn, xgmiiLoopbackEn}, 16'h0003);
        xlc_mgmt_host_inst.wr(xlc_pkg::ADDR_LOOP, 16'h0001);
        repeat (2) @(negedge clk);
        check({14'h0000, xauiLoopbackEn, xgmiiLoopbackEn}, 16'h0001);
        xlc_mgmt_host_inst.wr(xlc_pkg::ADDR_RATE, 16'hffff);
        rdChk(xlc_pkg::ADDR_RATE, 16'h0000);
        // Sync flag latches low until read
        laneSync = 4'hf;
        rdChk(xlc_pkg::ADDR_SYNC, 16'h0000);
        rdChk(xlc_pkg::ADDR_SYNC, 16'h0800);
        laneSync = 4'hb;
        @(negedge clk);
        laneSync = 4'hf;
        rdChk(xlc_pkg::ADDR_SYNC, 16'h0000);
        rdChk(xlc_pkg::ADDR_SYNC, 16'h0800);
        // Rate compensation events, one cycle each
        rateOverflow = 4'h4;
        rateUnderflow = 4'h1;
        @(negedge clk);
        rateOverflow = 4'h0;
        rateUnderflow = 4'h0;
        repeat (3) @(negedge clk);
        rdChk(xlc_pkg::ADDR_RATE, 16'h0107);
        rdChk(xlc_pkg::ADDR_RATE, 16'h0000);
        // Idle tallies
        idleInsert = 1'b1;
        repeat (3) @(negedge clk);
        idleInsert = 1'b0;
        rdChk(xlc_pkg::ADDR_INS, 16'h0003);
        idleDelete = 1'b1;
        repeat (2) @(negedge clk);
        idleDelete = 1'b0;
        rdChk(xlc_pkg::ADDR_DEL, 16'h0002);
        doReset();
        idleInsert = 1'b1;
        idleDelete = 1'b1;
        repeat (4) @(negedge clk);
        rdChk(xlc_pkg::ADDR_DEL, 16'hffff);
        idleDelete = 1'b0;
        rdChk(xlc_pkg::ADDR_INS, 16'hffff);
        idleInsert = 1'b0;
        rdChk(xlc_pkg::ADDR_DEL, 16'h0001);
        rdChk(xlc_pkg::ADDR_INS, 16'h0001);
        // Lane 0 stops toggling
        laneToggle = 4'he;
        repeat (LIM - 2) @(negedge clk);
        rdChk(xlc_pkg::ADDR_DOWN, 16'h0000);
        rdChk(xlc_pkg::ADDR_DOWN, 16'h0001);
        rdChk(xlc_pkg::ADDR_DOWN, 16'h0000);
        laneToggle = 4'hf;
        completeRun();
    end
endmodule
`default_nettype wire
